/* swm_defs.svh */
// Constants for the sleep wake-up timer and monitor block
// Assumes a 100 MHz system clock and an 8-bit register port
`ifndef SWM_DEFS_SVH
`define SWM_DEFS_SVH
// Register offsets
`define SWM_A_TEMP_CTRL   7'h12
`define SWM_A_TEMP_OFFS   7'h13
`define SWM_A_WAKE_EXP    7'h14
`define SWM_A_WAKE_MHI    7'h15
`define SWM_A_WAKE_MLO    7'h16
`define SWM_A_WAKE_CHI    7'h17
`define SWM_A_WAKE_CLO    7'h18
`define SWM_A_BATT_THR    7'h1A
`define SWM_A_BATT_LVL    7'h1B
// Reset values
`define SWM_RST_TEMP_CTRL 8'h20
`define SWM_RST_BATT_THR  5'h14
// Field layout
`define SWM_TC_RANGE      7:6
`define SWM_TC_SHIFT      5
`define SWM_TC_TRIM_EN    4
`define SWM_TC_TRIM       3:0
`define SWM_WE_R          5:2
`define SWM_WE_D          1:0
`define SWM_TEMP_ADC_SEL  3'h0
`define SWM_PRESC_BASE    5'h05
`define SWM_BATT_CONSEC   3'h4
// Timing
`define SWM_CLK_HZ        100000000
`define SWM_CLK_MHZ       100
`define SWM_SLOW_HZ       32768
`define SWM_BATT_PER_MS   1000
`define SWM_BATT_MEAS_US  250
`define SWM_ADC_CONV_US   350
`define SWM_SLOW_DIV      ((`SWM_CLK_HZ + `SWM_SLOW_HZ / 2) / `SWM_SLOW_HZ)
`endif

/* swm_host_model.sv */
// Host model: register strobes, converter control and status reads
// Assumes the block samples its inputs on the rising clock edge
`timescale 1ns/10ps
`include "swm_defs.svh"
module swm_host_model
    import swm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       busy_i,
    output logic      [6:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            we_o,
    output logic            re_o,
    output logic            clr_o,
    output logic      [2:0] sel_o,
    output logic            start_o
);
    // Strobes idle low; released address and data show the inverse, never stale values
    initial begin
        addr_o  = 7'h00;
        wdata_o = 8'h00;
        we_o    = 1'b0;
        re_o    = 1'b0;
        clr_o   = 1'b0;
        sel_o   = 3'h1;
        start_o = 1'b0;
    end
    // One access, held across exactly one sampling edge; read data taken after it
    task automatic access(input logic [6:0] a, input logic [7:0] d, input logic wr,
                          output logic [7:0] q);
        @(posedge clk_i);
        #1;
        addr_o  = a;
        wdata_o = d;
        we_o    = wr;
        re_o    = !wr;
        @(posedge clk_i);
        #1;
        we_o    = 1'b0;
        re_o    = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
        q       = rdata_i;
    endtask
    // Converter input select, changed only just after an edge
    task automatic select(input logic [2:0] s);
        @(posedge clk_i);
        #1;
        sel_o = s;
    endtask
    // Host-side conversion of a sensor code, in half units of the range scale
    function automatic int temp_x2(input logic [1:0] rng, input logic [7:0] s);
        int lsb2;
        int low;
        lsb2 = rng[0] ? 2 : 1;
        low  = (rng == 2'b11) ? -40 : ((rng == 2'b10) ? 0 : -64);
        return int'(s) * lsb2 + 2 * low;
    endfunction
    // One-cycle clear strobe after the pin falls; clears the pending events
    task automatic ack();
        @(posedge clk_i);
        #1;
        clr_o = 1'b1;
        @(posedge clk_i);
        #1;
        clr_o = 1'b0;
    endtask
    // Temperature sample; the converter reference lives outside and stays at 00
    task automatic temp_sample(input logic [1:0] rng, output int busy_cyc);
        logic [7:0] q;
        int         n;
        busy_cyc = 0;
        sel_o = `SWM_TEMP_ADC_SEL;
        access(`SWM_A_TEMP_CTRL, {rng, 1'b1, 5'h00}, 1'b1, q);
        @(posedge clk_i);
        #1;
        start_o = 1'b1;
        @(posedge clk_i);
        #1;
        start_o = 1'b0;
        for (n = 0; n < 1000 && busy_i === 1'b1; n++) begin
            busy_cyc++;
            @(posedge clk_i);
            #1;
        end
    endtask
endmodule

/* swm_pkg.sv */
// Types for the sleep wake-up timer and monitor block
// Assumes swm_defs.svh supplies the numeric constants
package swm_pkg;
    typedef enum logic [1:0] {
        SWM_B_IDLE = 2'b00,
        SWM_B_WAIT = 2'b01,
        SWM_B_MEAS = 2'b10
    } swm_batt_state_t;
endpackage

/* swm_sleep_monitors.sv */
// Wake-up timer, battery monitor and temperature sensor control
// Assumes an SPI engine outside drives the 8-bit register port and
// that the battery code input is settled at the end of a measurement.
//
// Overview of operation
// - Sensor powers up when chosen as converter input or test bus.
// - Range code picks span and LSB while the shift is enabled.
// - Shift off with range 10 gives absolute kelvin; shift resets to 1.
// - Four-bit bandgap trim with a trim-enable bit.
// - Battery level below threshold with interrupt enabled drives pin low.
// - Battery level readable while monitor enabled; upper three bits zero.
// - Battery code is 50 mV per step from 1.7 V.
// - Detector powered once a second for about 250 us.
// - Interrupt only after four consecutive low readings.
// - Monitor enabled in sleep starts the slow RC oscillator unless the crystal is selected.
// - Detector runs only while the monitor enable bit is 1.
// - Timer counts slow ticks; runs in sleep if enabled at sleep entry.
// - Period is 32 x M x 2^(R-D) slow ticks.
// - Expiry drives the interrupt pin when enabled.
// - Running 16-bit count readable in two registers.
// - Expiry with interrupt enabled starts the fast crystal.
// - Expiry without interrupt only pulses the timer GPIO function.
// - Crystal select swaps the RC tick for the external crystal tick.
// - Converter start clears itself after 350 us.
`timescale 1ns/10ps
`include "swm_defs.svh"
module swm_sleep_monitors
    import swm_pkg::*;
#(
    parameter int BATT_PER_TICKS = `SWM_BATT_PER_MS * `SWM_SLOW_HZ / 1000,
    parameter int BATT_MEAS_CYC  = `SWM_BATT_MEAS_US * `SWM_CLK_MHZ,
    parameter int ADC_CONV_CYC   = `SWM_ADC_CONV_US * `SWM_CLK_MHZ
) (
    input  wire logic       CLK_I,
    input  wire logic       SRST_I,
    input  wire logic [6:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_WE_I,
    input  wire logic       REG_RE_I,
    output logic      [7:0] REG_RDATA_O,
    input  wire logic       SLEEP_I,
    input  wire logic       WAKE_EN_I,
    input  wire logic       BATT_EN_I,
    input  wire logic       XTAL_SEL_I,
    input  wire logic       XTAL_TICK_I,
    input  wire logic       WAKE_IRQ_EN_I,
    input  wire logic       BATT_IRQ_EN_I,
    input  wire logic       IRQ_CLEAR_I,
    input  wire logic [2:0] ADC_SEL_I,
    input  wire logic       TEST_BUS_TEMP_I,
    input  wire logic       ADC_START_I,
    input  wire logic [4:0] BATT_CODE_I,
    output logic            INTERRUPT_PIN_N_O,
    output logic            XTAL_START_O,
    output logic            WAKE_GPIO_O,
    output logic            RC_OSC_EN_O,
    output logic            BATT_DET_PWR_O,
    output logic            TEMP_SENSOR_PWR_O,
    output logic            ADC_BUSY_O,
    output logic      [1:0] TEMP_RANGE_O,
    output logic            TEMP_SHIFT_EN_O,
    output logic            TRIM_EN_O,
    output logic      [3:0] TRIM_O,
    output logic      [7:0] TEMP_OFFSET_O
);
    // Register storage
    logic [7:0]  temp_ctrl_q;
    logic [7:0]  temp_offs_q;
    logic [5:0]  wake_exp_q;
    logic [15:0] wake_m_q;
    logic [4:0]  batt_thr_q;
    logic [4:0]  batt_lvl_q;
    // Write strobes from the address decode
    wire wr_tc  = REG_WE_I && (REG_ADDR_I == `SWM_A_TEMP_CTRL);
    wire wr_to  = REG_WE_I && (REG_ADDR_I == `SWM_A_TEMP_OFFS);
    wire wr_we  = REG_WE_I && (REG_ADDR_I == `SWM_A_WAKE_EXP);
    wire wr_mh  = REG_WE_I && (REG_ADDR_I == `SWM_A_WAKE_MHI);
    wire wr_ml  = REG_WE_I && (REG_ADDR_I == `SWM_A_WAKE_MLO);
    wire wr_thr = REG_WE_I && (REG_ADDR_I == `SWM_A_BATT_THR);

    // Writable registers; shift enable comes out of reset set
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            temp_ctrl_q <= `SWM_RST_TEMP_CTRL;
            temp_offs_q <= 8'h00;
            wake_exp_q  <= 6'h00;
            wake_m_q    <= 16'h0000;
            batt_thr_q  <= `SWM_RST_BATT_THR;
        end else begin
            if (wr_tc)  temp_ctrl_q     <= REG_WDATA_I;
            if (wr_to)  temp_offs_q     <= REG_WDATA_I;
            if (wr_we)  wake_exp_q      <= REG_WDATA_I[5:0];
            if (wr_mh)  wake_m_q[15:8]  <= REG_WDATA_I;
            if (wr_ml)  wake_m_q[7:0]   <= REG_WDATA_I;
            if (wr_thr) batt_thr_q      <= REG_WDATA_I[4:0];
        end
    end

    // Read mux; reserved bits and unmapped addresses read zero
    logic [15:0] wtv_q;
    logic [7:0]  rd_mux;
    always_comb begin
        unique case (REG_ADDR_I)
            `SWM_A_TEMP_CTRL: rd_mux = temp_ctrl_q;
            `SWM_A_TEMP_OFFS: rd_mux = temp_offs_q;
            `SWM_A_WAKE_EXP:  rd_mux = {2'h0, wake_exp_q};
            `SWM_A_WAKE_MHI:  rd_mux = wake_m_q[15:8];
            `SWM_A_WAKE_MLO:  rd_mux = wake_m_q[7:0];
            `SWM_A_WAKE_CHI:  rd_mux = wtv_q[15:8];
            `SWM_A_WAKE_CLO:  rd_mux = wtv_q[7:0];
            `SWM_A_BATT_THR:  rd_mux = {3'h0, batt_thr_q};
            `SWM_A_BATT_LVL:  rd_mux = {3'h0, batt_lvl_q};
            default:          rd_mux = 8'h00;
        endcase
    end

    // Read data is held until the next read strobe
    always_ff @(posedge CLK_I) begin
        if (SRST_I) REG_RDATA_O <= 8'h00;
        else if (REG_RE_I) REG_RDATA_O <= rd_mux;
    end

    // Sensor control fields driven to the analog side
    assign TEMP_RANGE_O    = temp_ctrl_q[`SWM_TC_RANGE];
    assign TEMP_SHIFT_EN_O = temp_ctrl_q[`SWM_TC_SHIFT];
    assign TRIM_EN_O       = temp_ctrl_q[`SWM_TC_TRIM_EN];
    assign TRIM_O          = temp_ctrl_q[`SWM_TC_TRIM];
    assign TEMP_OFFSET_O   = temp_offs_q;

    // Slow tick: RC divider or the external crystal tick
    logic [11:0] div_q;
    wire div_end  = (div_q == 12'(`SWM_SLOW_DIV - 1));
    wire rc_tick  = div_end;
    wire slow_tick = XTAL_SEL_I ? XTAL_TICK_I : rc_tick;
    always_ff @(posedge CLK_I) begin
        if (SRST_I || div_end) div_q <= 12'h000;
        else div_q <= div_q + 12'h001;
    end

    // Sleep entry edge
    logic sleep_q;
    always_ff @(posedge CLK_I) begin
        if (SRST_I) sleep_q <= 1'b0;
        else sleep_q <= SLEEP_I;
    end
    wire sleep_rise = SLEEP_I && !sleep_q;

    // Wake timer: prescaler of 2^(5+R-D) ticks, then M periods
    logic        wake_run_q;
    logic [19:0] presc_q;
    logic [4:0]  sh_q;
    logic [15:0] m_sh_q;
    wire  [4:0]  sh_new = `SWM_PRESC_BASE + {1'b0, wake_exp_q[`SWM_WE_R]}
                          - {3'h0, wake_exp_q[`SWM_WE_D]};
    wire  [20:0] presc_top = (21'h000001 << sh_q) - 21'h000001;
    wire         presc_end = ({1'b0, presc_q} == presc_top);
    wire         wake_start = sleep_rise && WAKE_EN_I;
    wire         wake_stop  = !SLEEP_I || !WAKE_EN_I;
    wire         wake_step  = wake_run_q && slow_tick && presc_end;
    wire         wake_exp   = wake_step && (m_sh_q != 16'h0000)
                              && (wtv_q + 16'h0001 == m_sh_q);

    // Timer state; expiry reloads the period fields for the next period
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            wake_run_q <= 1'b0;
            presc_q    <= 20'h00000;
            sh_q       <= `SWM_PRESC_BASE;
            m_sh_q     <= 16'h0000;
            wtv_q      <= 16'h0000;
        end else if (wake_start || wake_exp) begin
            wake_run_q <= 1'b1;
            presc_q    <= 20'h00000;
            sh_q       <= sh_new;
            m_sh_q     <= wake_m_q;
            wtv_q      <= 16'h0000;
        end else if (wake_stop) begin
            wake_run_q <= 1'b0;
        end else if (wake_run_q && slow_tick) begin
            presc_q <= presc_end ? 20'h00000 : presc_q + 20'h00001;
            if (wake_step) wtv_q <= wtv_q + 16'h0001;
        end
    end

    // Battery sequencer: wait one second, power detector, sample
    swm_batt_state_t bst_q;
    swm_batt_state_t bst_d;
    logic [15:0] bper_q;
    logic [15:0] bmeas_q;
    logic [2:0]  low_cnt_q;
    wire per_end  = slow_tick && (bper_q == 16'(BATT_PER_TICKS - 1));
    wire meas_end = (bmeas_q == 16'(BATT_MEAS_CYC - 1));
    wire is_low   = (BATT_CODE_I < batt_thr_q);
    wire sample   = (bst_q == SWM_B_MEAS) && meas_end;

    // Next state; monitor enable gates the whole sequence
    always_comb begin
        bst_d = bst_q;
        unique case (bst_q)
            SWM_B_IDLE: if (BATT_EN_I) bst_d = SWM_B_WAIT;
            SWM_B_WAIT: if (per_end) bst_d = SWM_B_MEAS;
            SWM_B_MEAS: if (meas_end) bst_d = SWM_B_WAIT;
            default:    bst_d = SWM_B_IDLE;
        endcase
        if (!BATT_EN_I) bst_d = SWM_B_IDLE;
    end

    // Sequencer counters and consecutive-low tally
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            bst_q     <= SWM_B_IDLE;
            bper_q    <= 16'h0000;
            bmeas_q   <= 16'h0000;
            low_cnt_q <= 3'h0;
            batt_lvl_q <= 5'h00;
        end else begin
            bst_q <= bst_d;
            if (bst_q != SWM_B_WAIT || per_end) bper_q <= 16'h0000;
            else if (slow_tick) bper_q <= bper_q + 16'h0001;
            if (bst_q != SWM_B_MEAS || meas_end) bmeas_q <= 16'h0000;
            else bmeas_q <= bmeas_q + 16'h0001;
            if (!BATT_EN_I) low_cnt_q <= 3'h0;
            else if (sample) begin
                batt_lvl_q <= BATT_CODE_I;
                if (!is_low) low_cnt_q <= 3'h0;
                else if (low_cnt_q != `SWM_BATT_CONSEC)
                    low_cnt_q <= low_cnt_q + 3'h1;
            end
        end
    end
    // Event fires once, on the reading that completes the run of four
    wire batt_evt = sample && is_low
                    && (low_cnt_q == `SWM_BATT_CONSEC - 3'h1);

    // Pending events; a new event wins over the host clear
    logic wake_pend_q;
    logic batt_pend_q;
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            wake_pend_q <= 1'b0;
            batt_pend_q <= 1'b0;
        end else begin
            if (wake_exp && WAKE_IRQ_EN_I) wake_pend_q <= 1'b1;
            else if (IRQ_CLEAR_I) wake_pend_q <= 1'b0;
            if (batt_evt && BATT_IRQ_EN_I) batt_pend_q <= 1'b1;
            else if (IRQ_CLEAR_I) batt_pend_q <= 1'b0;
        end
    end

    // Converter busy flag clears itself after the conversion time
    logic [15:0] adc_cnt_q;
    wire adc_end = ADC_BUSY_O && (adc_cnt_q == 16'(ADC_CONV_CYC - 1));
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ADC_BUSY_O <= 1'b0;
            adc_cnt_q  <= 16'h0000;
        end else if (ADC_START_I && !ADC_BUSY_O) begin
            ADC_BUSY_O <= 1'b1;
            adc_cnt_q  <= 16'h0000;
        end else if (adc_end) begin
            ADC_BUSY_O <= 1'b0;
        end else if (ADC_BUSY_O) begin
            adc_cnt_q <= adc_cnt_q + 16'h0001;
        end
    end

    // Pin-facing outputs, all registered to keep them glitch free
    wire temp_pwr_d = (ADC_SEL_I == `SWM_TEMP_ADC_SEL) || TEST_BUS_TEMP_I;
    wire rc_en_d = SLEEP_I && !XTAL_SEL_I && (BATT_EN_I || wake_run_q);
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            INTERRUPT_PIN_N_O <= 1'b1;
            XTAL_START_O      <= 1'b0;
            WAKE_GPIO_O       <= 1'b0;
            RC_OSC_EN_O       <= 1'b0;
            BATT_DET_PWR_O    <= 1'b0;
            TEMP_SENSOR_PWR_O <= 1'b0;
        end else begin
            INTERRUPT_PIN_N_O <= !(wake_pend_q || batt_pend_q);
            // Crystal start holds until the host takes the part out of sleep
            if (wake_exp && WAKE_IRQ_EN_I) XTAL_START_O <= 1'b1;
            else if (!SLEEP_I) XTAL_START_O <= 1'b0;
            WAKE_GPIO_O       <= wake_exp && !WAKE_IRQ_EN_I;
            RC_OSC_EN_O       <= rc_en_d;
            BATT_DET_PWR_O    <= (bst_d == SWM_B_MEAS);
            TEMP_SENSOR_PWR_O <= temp_pwr_d;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    property p_temp_pwr;
        temp_pwr_d |=> TEMP_SENSOR_PWR_O;
    endproperty
    a_temp_pwr: assert property (p_temp_pwr)
        else $error("sensor power missing");

    property p_batt_irq;
        batt_evt && BATT_IRQ_EN_I |=> batt_pend_q ##1 !INTERRUPT_PIN_N_O;
    endproperty
    a_batt_irq: assert property (p_batt_irq)
        else $error("battery interrupt missing");

    property p_lvl_read;
        REG_RE_I && REG_ADDR_I == `SWM_A_BATT_LVL |=> REG_RDATA_O[7:5] == 3'h0
            && REG_RDATA_O[4:0] == $past(batt_lvl_q);
    endproperty
    a_lvl_read: assert property (p_lvl_read)
        else $error("battery level read wrong");

    property p_meas_len;
        $rose(BATT_DET_PWR_O) |-> BATT_DET_PWR_O [*8];
    endproperty
    a_meas_len: assert property (p_meas_len)
        else $error("detector power too short");

    property p_consec;
        batt_evt |-> low_cnt_q == 3'h3 && is_low;
    endproperty
    a_consec: assert property (p_consec)
        else $error("battery event before four lows");

    property p_batt_off;
        !BATT_EN_I |=> bst_q == SWM_B_IDLE ##1 !BATT_DET_PWR_O;
    endproperty
    a_batt_off: assert property (p_batt_off)
        else $error("detector runs while disabled");

    property p_wake_start;
        !SLEEP_I ##1 SLEEP_I && !WAKE_EN_I |=> !wake_run_q;
    endproperty
    a_wake_start: assert property (p_wake_start)
        else $error("timer ran without enable");

    property p_xtal;
        wake_exp && WAKE_IRQ_EN_I |=> ##1 XTAL_START_O && !INTERRUPT_PIN_N_O;
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("crystal or pin not driven on expiry");

    property p_gpio_only;
        wake_exp && !WAKE_IRQ_EN_I && !wake_pend_q && !batt_pend_q
            |=> WAKE_GPIO_O && $stable(XTAL_START_O);
    endproperty
    a_gpio_only: assert property (p_gpio_only)
        else $error("expiry without interrupt misbehaved");

    property p_restart;
        wake_exp && !wake_stop |=> wake_run_q && wtv_q == 16'h0000;
    endproperty
    a_restart: assert property (p_restart)
        else $error("timer did not restart");

    property p_adc_clear;
        adc_end |=> !ADC_BUSY_O;
    endproperty
    a_adc_clear: assert property (p_adc_clear)
        else $error("converter busy stuck");

    c_wake_exp: cover property (wake_exp && WAKE_IRQ_EN_I);
    c_batt_evt: cover property (batt_evt);
    c_adc_done: cover property (adc_end);
endmodule

/* test_sleep_wakeup_and_monitors.sv */
// Self-checking bench for the sleep wake-up timer and monitor block
// Assumes the host model owns the register port, converter start and status reads
`timescale 1ns/10ps
`include "swm_defs.svh"
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
    end \
end
module test_sleep_wakeup_and_monitors
    import swm_pkg::*;
;
    logic       CLK_I, SRST_I, REG_WE_I, REG_RE_I, SLEEP_I, WAKE_EN_I, BATT_EN_I;
    logic       XTAL_SEL_I, XTAL_TICK_I, WAKE_IRQ_EN_I, BATT_IRQ_EN_I, IRQ_CLEAR_I;
    logic       TEST_BUS_TEMP_I, ADC_START_I, INTERRUPT_PIN_N_O, XTAL_START_O;
    logic       WAKE_GPIO_O, RC_OSC_EN_O, BATT_DET_PWR_O, TEMP_SENSOR_PWR_O, ADC_BUSY_O;
    logic       TEMP_SHIFT_EN_O, TRIM_EN_O;
    logic [1:0] TEMP_RANGE_O;
    logic [2:0] ADC_SEL_I;
    logic [3:0] TRIM_O;
    logic [4:0] BATT_CODE_I, code;
    logic [6:0] REG_ADDR_I;
    logic [7:0] REG_WDATA_I, REG_RDATA_O, TEMP_OFFSET_O, q, d;
    logic       pend;
    int         miscompares = 0, compares = 0, cyc = 0, ticks = 0, t_start = 0;
    int         seed = 32'h0A06, got, n, i, len, lowcnt;
    logic [6:0] ra [6] = '{`SWM_A_TEMP_CTRL, `SWM_A_TEMP_OFFS, `SWM_A_WAKE_EXP,
                           `SWM_A_WAKE_MHI, `SWM_A_WAKE_MLO, `SWM_A_BATT_THR};
    logic [7:0] rv [6] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14};
    logic [7:0] rm [6] = '{8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h1F};

    swm_sleep_monitors #(.BATT_PER_TICKS(4), .BATT_MEAS_CYC(10), .ADC_CONV_CYC(10))
    swm_sleep_monitors_inst (.CLK_I(CLK_I), .SRST_I(SRST_I), .REG_ADDR_I(REG_ADDR_I),
        .REG_WDATA_I(REG_WDATA_I), .REG_WE_I(REG_WE_I), .REG_RE_I(REG_RE_I),
        .REG_RDATA_O(REG_RDATA_O), .SLEEP_I(SLEEP_I), .WAKE_EN_I(WAKE_EN_I),
        .BATT_EN_I(BATT_EN_I), .XTAL_SEL_I(XTAL_SEL_I), .XTAL_TICK_I(XTAL_TICK_I),
        .WAKE_IRQ_EN_I(WAKE_IRQ_EN_I), .BATT_IRQ_EN_I(BATT_IRQ_EN_I),
        .IRQ_CLEAR_I(IRQ_CLEAR_I), .ADC_SEL_I(ADC_SEL_I), .TEST_BUS_TEMP_I(TEST_BUS_TEMP_I),
        .ADC_START_I(ADC_START_I), .BATT_CODE_I(BATT_CODE_I),
        .INTERRUPT_PIN_N_O(INTERRUPT_PIN_N_O), .XTAL_START_O(XTAL_START_O),
        .WAKE_GPIO_O(WAKE_GPIO_O), .RC_OSC_EN_O(RC_OSC_EN_O), .BATT_DET_PWR_O(BATT_DET_PWR_O),
        .TEMP_SENSOR_PWR_O(TEMP_SENSOR_PWR_O), .ADC_BUSY_O(ADC_BUSY_O),
        .TEMP_RANGE_O(TEMP_RANGE_O), .TEMP_SHIFT_EN_O(TEMP_SHIFT_EN_O),
        .TRIM_EN_O(TRIM_EN_O), .TRIM_O(TRIM_O), .TEMP_OFFSET_O(TEMP_OFFSET_O));
    swm_host_model swm_host_model_inst (.clk_i(CLK_I), .rdata_i(REG_RDATA_O),
        .busy_i(ADC_BUSY_O), .addr_o(REG_ADDR_I), .wdata_o(REG_WDATA_I), .we_o(REG_WE_I),
        .re_o(REG_RE_I), .clr_o(IRQ_CLEAR_I), .sel_o(ADC_SEL_I), .start_o(ADC_START_I));

    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end
    // Crystal tick every fourth cycle, counted at the edge that consumes it
    always @(posedge CLK_I) begin
        cyc <= cyc + 1;
        ticks <= ticks + (XTAL_TICK_I ? 1 : 0);
        #1;
        XTAL_TICK_I = (cyc % 4 == 0);
    end
    task automatic print_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge CLK_I);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] x;
        swm_host_model_inst.access(a, v, 1'b1, x);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        swm_host_model_inst.access(a, 8'h00, 1'b0, v);
    endtask
    // Reference period in slow ticks
    function automatic int per(input int m, input int r, input int dd);
        return 32 * m * (2 ** (r - dd));
    endfunction
    // Sleep entry placed two cycles before a tick, so tick counting is exact
    task automatic enter_sleep();
        while (cyc % 4 != 2) cycles(1);
        SLEEP_I = 1'b1;
        t_start = ticks;
    endtask
    // Ticks from the last start to the expiry seen at the pins; -1 when none comes
    task automatic wait_evt(input int lim, input bit must, output int n_t);
        int k;
        n_t = -1;
        for (k = 0; k < lim && n_t < 0; k++) begin
            cycles(1);
            if ((WAKE_IRQ_EN_I ? !INTERRUPT_PIN_N_O : WAKE_GPIO_O) === 1'b1) n_t = ticks - t_start;
        end
        t_start = ticks;
        if (must && n_t < 0) begin
            miscompares++;
            print_verdict();
        end
    endtask
    // Hang guard well inside the cycle budget
    initial begin
        #900000;
        miscompares++;
        print_verdict();
    end
    initial begin
        {SLEEP_I, WAKE_EN_I, BATT_EN_I, XTAL_SEL_I} = 4'h0;
        {WAKE_IRQ_EN_I, BATT_IRQ_EN_I, TEST_BUS_TEMP_I, pend, lowcnt} = 0;
        BATT_CODE_I = 5'h00;
        SRST_I = 1'b1;
        cycles(20);
        SRST_I = 1'b0;
        `CHK("pin_rst", 1'b1, INTERRUPT_PIN_N_O)
        `CHK("shift_rst", 1'b1, TEMP_SHIFT_EN_O)
        for (n = 0; n < 6; n++) begin
            rd(ra[n], q);
            `CHK("reg_rst", rv[n], q)
        end
        // Random register traffic; unused bits must read back as zero
        for (n = 0; n < 12; n++) begin
            d = 8'($random(seed));
            wr(ra[n % 6], d);
            rd(ra[n % 6], q);
            `CHK("reg_rw", d & rm[n % 6], q)
            if (n % 6 == 0) `CHK("tc_fld", d, {TEMP_RANGE_O, TEMP_SHIFT_EN_O, TRIM_EN_O, TRIM_O})
            if (n % 6 == 1) `CHK("offset", d, TEMP_OFFSET_O)
        end
        wr(7'h19, 8'hA5);
        rd(7'h19, q);
        `CHK("unmapped", 8'h00, q)
        // Every range code through a full sample sequence
        for (n = 0; n < 4; n++) begin
            swm_host_model_inst.temp_sample(n[1:0], got);
            `CHK("adc_busy", 10, got)
            `CHK("range", n[1:0], TEMP_RANGE_O)
            `CHK("ts_pwr", 1'b1, TEMP_SENSOR_PWR_O)
        end
        // Sample codes turned into temperature at the low end of range 00 and the high end of range 11
        `CHK("t_conv", -128, swm_host_model_inst.temp_x2(2'b00, 8'h00))
        `CHK("t_conv", 430, swm_host_model_inst.temp_x2(2'b11, 8'hFF))
        swm_host_model_inst.select(3'h1);
        cycles(2);
        `CHK("ts_off", 1'b0, TEMP_SENSOR_PWR_O)
        TEST_BUS_TEMP_I = 1'b1;
        cycles(2);
        `CHK("ts_bus", 1'b1, TEMP_SENSOR_PWR_O)
        TEST_BUS_TEMP_I = 1'b0;
        BATT_EN_I = 1'b1;
        SLEEP_I = 1'b1;
        cycles(3);
        `CHK("rc_en", 1'b1, RC_OSC_EN_O)
        {BATT_EN_I, SLEEP_I} = 2'b00;
        cycles(2);
        // Battery: three lows, one equal to the threshold, then four lows
        XTAL_SEL_I = 1'b1;
        BATT_IRQ_EN_I = 1'b1;
        wr(`SWM_A_BATT_THR, 8'h10);
        BATT_EN_I = 1'b1;
        for (n = 0; n < 8; n++) begin
            d = 8'($random(seed));
            code = (n == 3) ? 5'h10 : {1'b0, d[3:0]};
            BATT_CODE_I = code;
            for (i = 0; i < 2000 && BATT_DET_PWR_O !== 1'b1; i++) cycles(1);
            if (i == 2000) begin
                miscompares++;
                print_verdict();
            end
            for (len = 0; len < 2000 && BATT_DET_PWR_O === 1'b1; len++) cycles(1);
            `CHK("meas_len", 10, len)
            lowcnt = (code < 5'h10) ? ((lowcnt < 4) ? lowcnt + 1 : 4) : 0;
            pend = pend | (lowcnt == 4);
            rd(`SWM_A_BATT_LVL, q);
            `CHK("batt_lvl", {3'h0, code}, q)
            cycles(1);
            `CHK("batt_pin", !pend, INTERRUPT_PIN_N_O)
        end
        swm_host_model_inst.ack();
        cycles(1);
        `CHK("pin_clr", 1'b1, INTERRUPT_PIN_N_O)
        BATT_EN_I = 1'b0;
        cycles(3);
        for (len = 0, i = 0; i < 200; i++) begin
            cycles(1);
            len += (BATT_DET_PWR_O === 1'b0) ? 0 : 1;
        end
        `CHK("batt_off", 0, len)
        // Wake timer on the crystal tick; new fields apply one period later
        wr(`SWM_A_WAKE_MHI, 8'h00);
        wr(`SWM_A_WAKE_MLO, 8'h01);
        wr(`SWM_A_WAKE_EXP, 8'h04);
        {WAKE_EN_I, WAKE_IRQ_EN_I} = 2'b11;
        enter_sleep();
        wait_evt(3000, 1, got);
        `CHK("wake_p1", per(1, 1, 0), got)
        `CHK("xtal_st", 1'b1, XTAL_START_O)
        swm_host_model_inst.ack();
        wr(`SWM_A_WAKE_MLO, 8'h02);
        wr(`SWM_A_WAKE_EXP, 8'h09);
        wait_evt(3000, 1, got);
        `CHK("wake_p2", per(1, 1, 0), got)
        swm_host_model_inst.ack();
        wait_evt(3000, 1, got);
        `CHK("wake_p3", per(2, 2, 1), got)
        swm_host_model_inst.ack();
        WAKE_IRQ_EN_I = 1'b0;
        wait_evt(3000, 1, got);
        `CHK("wake_gpio", per(2, 2, 1), got)
        `CHK("pin_quiet", 1'b1, INTERRUPT_PIN_N_O)
        // Eighty ticks into the next period: one 64-tick span counted
        cycles(320);
        rd(`SWM_A_WAKE_CLO, q);
        `CHK("wake_cnt_lo", 8'h01, q)
        rd(`SWM_A_WAKE_CHI, q);
        `CHK("wake_cnt_hi", 8'h00, q)
        SLEEP_I = 1'b0;
        cycles(2);
        `CHK("xtal_off", 1'b0, XTAL_START_O)
        // Enable raised only after sleep entry must not start the timer
        WAKE_EN_I = 1'b0;
        enter_sleep();
        cycles(2);
        WAKE_EN_I = 1'b1;
        wait_evt(1500, 0, got);
        `CHK("late_en", -1, got)
        SLEEP_I = 1'b0;
        print_verdict();
    end
endmodule
